// file: design/tam_pkg.sv
// Constants, register map and state encoding for the target approach monitor
package tam_pkg;

    localparam int unsigned DW = 32;
    localparam int unsigned AW = 8;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
    localparam logic [AW-1:0] OFS_TARGET    = 8'h04;
    localparam logic [AW-1:0] OFS_SWOVER    = 8'h08;
    localparam logic [AW-1:0] OFS_SWOFF     = 8'h0C;
    localparam logic [AW-1:0] OFS_TGTRANGE  = 8'h10;
    localparam logic [AW-1:0] OFS_STILLRNG  = 8'h14;
    localparam logic [AW-1:0] OFS_STILLVEL  = 8'h18;
    localparam logic [AW-1:0] OFS_MONPERIOD = 8'h1C;
    localparam logic [AW-1:0] OFS_STATUS    = 8'h20;
    localparam logic [AW-1:0] OFS_ACTPOS    = 8'h24;
    localparam logic [AW-1:0] OFS_IRQSTAT   = 8'h28;
    localparam logic [AW-1:0] OFS_IRQMASK   = 8'h2C;

    // Control word fields
    localparam int unsigned CTRL_START   = 0;
    localparam int unsigned CTRL_STOP    = 1;
    localparam int unsigned CTRL_ABORT   = 2;
    localparam int unsigned CTRL_MODE_LO = 3;
    localparam int unsigned CTRL_MODE_HI = 4;
    localparam int unsigned CTRL_DIR     = 5;

    // Operating modes
    localparam logic [1:0] MODE_INC = 2'h0;
    localparam logic [1:0] MODE_JOG = 2'h1;
    localparam logic [1:0] MODE_REF = 2'h2;

    // Interrupt status and mask layout
    localparam int unsigned IRQ_W        = 4;
    localparam int unsigned IRQ_REACHED  = 0;
    localparam int unsigned IRQ_TIMEOUT  = 1;
    localparam int unsigned IRQ_STILLERR = 2;
    localparam int unsigned IRQ_ABORT    = 3;

    // Status word layout
    localparam int unsigned STS_W       = 9;
    localparam int unsigned STS_REACHED = 3;
    localparam int unsigned STS_HOLD    = 4;
    localparam int unsigned STS_RAPID   = 5;
    localparam int unsigned STS_CREEP   = 6;
    localparam int unsigned STS_FWD     = 7;
    localparam int unsigned STS_ENTERED = 8;

    // Reset values
    localparam logic [DW-1:0]    RST_WORD = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ  = 4'h0;

    // Axis sequencer states, Gray coded along the approach path
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_RAPID    = 3'b001,
        ST_CREEP    = 3'b011,
        ST_APPROACH = 3'b010,
        ST_HOLD     = 3'b110,
        ST_MANUAL   = 3'b100
    } tam_state_e;

endpackage

// file: design/tam_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/10ps
`default_nettype none
module tam_sync
    import tam_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pinIn,
    output var  logic levelOut
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
        end else begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // Output follows once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            levelOut <= 1'b0;
        end else if (stage2_q == stage3_q) begin
            levelOut <= stage3_q;
        end
    end

endmodule
`default_nettype wire

// file: design/tam_dist.sv
// Remaining distance and absolute deviation of the axis from its target
`timescale 1ns/10ps
`default_nettype none
module tam_dist
    import tam_pkg::*;
(
    input  wire logic signed [DW-1:0] actualPos,
    input  wire logic signed [DW-1:0] targetPos,
    input  wire logic                 moveFwd,
    output logic signed [DW:0]        remaining,
    output logic        [DW:0]        deviation
);

    logic signed [DW:0] posExt;
    logic signed [DW:0] tgtExt;
    logic signed [DW:0] tgtMinusPos;

    // Widen by one bit so the difference never wraps
    assign posExt      = {actualPos[DW-1], actualPos};
    assign tgtExt      = {targetPos[DW-1], targetPos};
    assign tgtMinusPos = tgtExt - posExt;

    // Distance still to go in the travel direction; negative after overshoot
    assign remaining = moveFwd ? tgtMinusPos : -tgtMinusPos;
    assign deviation = tgtMinusPos[DW] ? $unsigned(-tgtMinusPos) : $unsigned(tgtMinusPos);

endmodule
`default_nettype wire

// file: design/tam_top.sv
// Target approach monitor: rapid/creep/off sequencing and approach supervision
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tam_top
    import tam_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [AW-1:0]        regAddr,
    input  wire logic [DW-1:0]        regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output var  logic [DW-1:0]        regRdata,
    input  wire logic signed [DW-1:0] actualPos,
    input  wire logic [DW-1:0]        actualVel,
    input  wire logic                 abortPinN,
    output var  logic                 driveRapid,
    output var  logic                 driveCreep,
    output var  logic                 driveFwd,
    output var  logic                 targetReachedFlag,
    output var  logic                 holdAtTargetSignal,
    output var  logic                 irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    tam_state_e             state_q;
    tam_state_e             state_d;
    logic signed [DW-1:0]   target_q;
    logic [DW-1:0]          swOver_q;
    logic [DW-1:0]          swOff_q;
    logic [DW-1:0]          tgtRange_q;
    logic [DW-1:0]          stillRange_q;
    logic [DW-1:0]          stillVel_q;
    logic [DW-1:0]          monPeriod_q;
    logic [DW-1:0]          monCount_q;
    logic [1:0]             mode_q;
    logic                   entered_q;
    logic                   velChecked_q;
    logic [IRQ_W-1:0]       irqStat_q;
    logic [IRQ_W-1:0]       irqMask_q;
    logic                   abortPin;
    logic signed [DW:0]     remaining;
    logic [DW:0]            deviation;

    ////////////////////////////////////////////////////////////////////////////////
    // Abort pin synchroniser and distance arithmetic

    tam_sync u_abortSync (
        .clk      (clk),
        .resetn   (resetn),
        .pinIn    (~abortPinN),
        .levelOut (abortPin)
    );

    tam_dist u_dist (
        .actualPos (actualPos),
        .targetPos (target_q),
        .moveFwd   (driveFwd),
        .remaining (remaining),
        .deviation (deviation)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic wrCtrl;
    logic wrIrqStat;
    logic wrIrqMask;
    logic startReq;
    logic stopReq;
    logic abortReq;
    logic [1:0] newMode;
    logic newFwd;

    // Write strobes per register and control pulses
    assign wrCtrl    = regWrite && (regAddr == OFS_CTRL);
    assign wrIrqStat = regWrite && (regAddr == OFS_IRQSTAT);
    assign wrIrqMask = regWrite && (regAddr == OFS_IRQMASK);
    assign startReq  = wrCtrl && regWdata[CTRL_START];
    assign stopReq   = wrCtrl && regWdata[CTRL_STOP];
    assign abortReq  = (wrCtrl && regWdata[CTRL_ABORT]) || abortPin;
    assign newMode   = regWdata[CTRL_MODE_HI:CTRL_MODE_LO];
    assign newFwd    = (newMode == MODE_INC) ? (target_q > actualPos) : regWdata[CTRL_DIR];

    ////////////////////////////////////////////////////////////////////////////////
    // Range and threshold comparisons

    logic atSwOver;
    logic atSwOff;
    logic inTarget;
    logic inStill;
    logic velStill;
    logic monExpired;
    logic undercut;

    // Distances compared as positive signed values
    assign atSwOver   = remaining <= $signed({1'b0, swOver_q});
    assign atSwOff    = remaining <= $signed({1'b0, swOff_q});
    assign inTarget   = deviation <= {2'b00, tgtRange_q[DW-1:1]}; // symmetric half range
    assign inStill    = deviation <= {2'b00, stillRange_q[DW-1:1]};
    assign velStill   = actualVel <= stillVel_q;
    assign monExpired = monCount_q >= monPeriod_q;
    assign undercut   = inTarget && velStill && !velChecked_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer next state

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (startReq && newMode == MODE_INC) begin
                    state_d = ST_RAPID;
                end else if (startReq) begin
                    state_d = ST_MANUAL;
                end
            end
            ST_RAPID: begin
                if (atSwOff) begin
                    state_d = ST_APPROACH;
                end else if (atSwOver) begin
                    state_d = ST_CREEP;
                end
            end
            ST_CREEP: begin
                if (atSwOff) begin
                    state_d = ST_APPROACH;
                end
            end
            ST_APPROACH: begin
                if (undercut || monExpired) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (startReq && newMode == MODE_INC) begin
                    state_d = ST_RAPID;
                end else if (startReq) begin
                    state_d = ST_MANUAL;
                end
            end
            ST_MANUAL: begin
                state_d = ST_MANUAL;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (stopReq && state_q != ST_HOLD) begin
            state_d = ST_IDLE;
        end
        if (abortReq) begin
            state_d = ST_IDLE;
        end
    end

    // Sequencer state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive outputs towards the power controller

    logic rapid_d;
    logic creep_d;

    // Rapid until switchover, creep until switch-off, jog and search at rapid
    assign rapid_d = (state_d == ST_RAPID) || (state_d == ST_MANUAL);
    assign creep_d = (state_d == ST_CREEP);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            driveRapid <= 1'b0;
            driveCreep <= 1'b0;
        end else begin
            driveRapid <= rapid_d;
            driveCreep <= creep_d;
        end
    end

    // Direction and mode latched at each start accepted in idle or hold
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            driveFwd <= 1'b0;
            mode_q   <= MODE_INC;
        end else if (startReq && (state_q == ST_IDLE || state_q == ST_HOLD) && !abortReq) begin
            driveFwd <= newFwd;
            mode_q   <= newMode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Approach supervision timer

    // Counts only during approach; frozen once reached or expired
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            monCount_q <= RST_WORD;
        end else if (state_q != ST_APPROACH) begin
            monCount_q <= RST_WORD;
        end else if (!undercut && !monExpired) begin
            monCount_q <= monCount_q + 32'h0000_0001;
        end
    end

    // Target range entry and single undercut evaluation per approach
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            entered_q    <= 1'b0;
            velChecked_q <= 1'b0;
        end else if (state_q == ST_RAPID) begin
            entered_q    <= 1'b0;
            velChecked_q <= 1'b0;
        end else if (state_q == ST_APPROACH) begin
            entered_q    <= entered_q || inTarget;
            velChecked_q <= velChecked_q || undercut;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reached flag, hold signal and standstill supervision

    logic reachedSet;
    logic holdSet;
    logic timeoutEv;
    logic stillErrEv;
    logic abortEv;
    logic leaveHold;

    assign reachedSet = (state_q == ST_APPROACH) && undercut && (mode_q == MODE_INC);
    assign holdSet    = (state_q == ST_APPROACH) && (state_d == ST_HOLD);
    assign timeoutEv  = (state_q == ST_APPROACH) && monExpired && !entered_q && !inTarget;
    assign stillErrEv = holdAtTargetSignal && !inStill && !startReq;
    assign abortEv    = abortReq && (state_q != ST_IDLE);
    assign leaveHold  = (state_d != ST_HOLD);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            targetReachedFlag <= 1'b0;
        end else if (startReq || abortReq || stopReq) begin
            targetReachedFlag <= 1'b0;
        end else if (reachedSet) begin
            targetReachedFlag <= 1'b1;
        end
    end

    // Hold signal arms the standstill window after the approach
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            holdAtTargetSignal <= 1'b0;
        end else if (holdSet) begin
            holdAtTargetSignal <= 1'b1;
        end else if (leaveHold) begin
            holdAtTargetSignal <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            target_q     <= RST_WORD;
            swOver_q     <= RST_WORD;
            swOff_q      <= RST_WORD;
            tgtRange_q   <= RST_WORD;
            stillRange_q <= RST_WORD;
            stillVel_q   <= RST_WORD;
            monPeriod_q  <= RST_WORD;
        end else if (regWrite) begin
            if (regAddr == OFS_TARGET) begin
                target_q <= regWdata;
            end
            if (regAddr == OFS_SWOVER) begin
                swOver_q <= regWdata;
            end
            if (regAddr == OFS_SWOFF) begin
                swOff_q <= regWdata;
            end
            if (regAddr == OFS_TGTRANGE) begin
                tgtRange_q <= regWdata;
            end
            if (regAddr == OFS_STILLRNG) begin
                stillRange_q <= regWdata;
            end
            if (regAddr == OFS_STILLVEL) begin
                stillVel_q <= regWdata;
            end
            if (regAddr == OFS_MONPERIOD) begin
                monPeriod_q <= regWdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and request line

    logic [IRQ_W-1:0] irqEvents;
    logic [IRQ_W-1:0] irqClear;

    assign irqEvents = {abortEv, stillErrEv, timeoutEv, reachedSet};
    assign irqClear  = wrIrqStat ? regWdata[IRQ_W-1:0] : RST_IRQ;

    // Sticky bits, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqStat_q <= RST_IRQ;
            irqMask_q <= RST_IRQ;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClear) | irqEvents;
            if (wrIrqMask) begin
                irqMask_q <= regWdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path, data one cycle after the strobe

    logic [STS_W-1:0] statusWord;
    logic [DW-1:0]    readMux;

    assign statusWord = {entered_q, driveFwd, driveCreep, driveRapid,
                         holdAtTargetSignal, targetReachedFlag, state_q};

    always_comb begin
        readMux = RST_WORD;
        unique case (regAddr)
            OFS_CTRL:      readMux = {{(DW-5){1'b0}}, mode_q, 3'b000};
            OFS_TARGET:    readMux = target_q;
            OFS_SWOVER:    readMux = swOver_q;
            OFS_SWOFF:     readMux = swOff_q;
            OFS_TGTRANGE:  readMux = tgtRange_q;
            OFS_STILLRNG:  readMux = stillRange_q;
            OFS_STILLVEL:  readMux = stillVel_q;
            OFS_MONPERIOD: readMux = monPeriod_q;
            OFS_STATUS:    readMux = {{(DW-STS_W){1'b0}}, statusWord};
            OFS_ACTPOS:    readMux = actualPos;
            OFS_IRQSTAT:   readMux = {{(DW-IRQ_W){1'b0}}, irqStat_q};
            OFS_IRQMASK:   readMux = {{(DW-IRQ_W){1'b0}}, irqMask_q};
            default:       readMux = RST_WORD;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= RST_WORD;
        end else if (regRead) begin
            regRdata <= readMux;
        end else begin
            regRdata <= RST_WORD;
        end
    end

endmodule
`default_nettype wire

// file: test/tam_top_sva.sv
// Port-level assertion checker for the target approach monitor
`timescale 1ns/10ps
`default_nettype none
module tam_top_sva
    import tam_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [AW-1:0]        regAddr,
    input wire logic [DW-1:0]        regWdata,
    input wire logic                 regWrite,
    input wire logic                 regRead,
    input wire logic [DW-1:0]        regRdata,
    input wire logic signed [DW-1:0] actualPos,
    input wire logic [DW-1:0]        actualVel,
    input wire logic                 abortPinN,
    input wire logic                 driveRapid,
    input wire logic                 driveCreep,
    input wire logic                 driveFwd,
    input wire logic                 targetReachedFlag,
    input wire logic                 holdAtTargetSignal,
    input wire logic                 irq
);
    logic        [DW-1:0]    tgt_q;
    logic        [DW-1:0]    rng_q;
    logic        [DW-1:0]    still_q;
    logic        [DW-1:0]    vel_q;
    logic        [IRQ_W-1:0] mask_q;
    logic signed [DW:0]      diff;
    logic        [DW:0]      absDev;
    wire                     ctrlWr = regWrite && (regAddr == OFS_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies of the settings that the assertions need
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tgt_q <= RST_WORD;
            rng_q <= RST_WORD;
            still_q <= RST_WORD;
            vel_q <= RST_WORD;
            mask_q <= RST_IRQ;
        end else if (regWrite) begin
            if (regAddr == OFS_TARGET) tgt_q <= regWdata;
            if (regAddr == OFS_TGTRANGE) rng_q <= regWdata;
            if (regAddr == OFS_STILLRNG) still_q <= regWdata;
            if (regAddr == OFS_STILLVEL) vel_q <= regWdata;
            if (regAddr == OFS_IRQMASK) mask_q <= regWdata[IRQ_W-1:0];
        end
    end

    // Distance of the axis from the shadowed target
    assign diff = $signed({actualPos[DW-1], actualPos}) - $signed({tgt_q[DW-1], tgt_q});
    assign absDev = diff[DW] ? $unsigned(-diff) : $unsigned(diff);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_ONE_SPEED: assert property (
        !(driveRapid && driveCreep)) else $error("Rapid and creep both on");
    AST_CREEP_ENTRY: assert property (
        $rose(driveCreep) |-> $past(driveRapid)) else $error("Creep not entered from rapid");
    AST_CREEP_OFF: assert property (
        $fell(driveCreep) |-> !driveRapid) else $error("Creep went back to rapid");
    AST_ABORT_OFF: assert property (
        ctrlWr && regWdata[CTRL_ABORT] |=> !driveRapid && !driveCreep)
        else $error("Drive still on after abort");
    AST_REACH_COND: assert property (
        $rose(targetReachedFlag) |-> $past(actualVel) <= vel_q
            && $past(absDev) <= {1'b0, rng_q >> 1}) else $error("Reached outside limits");
    AST_REACH_HOLD: assert property (
        $rose(targetReachedFlag) |-> holdAtTargetSignal) else $error("Reached without hold");
    AST_HOLD_AFTER_OFF: assert property (
        $rose(holdAtTargetSignal) |-> !$past(driveRapid) && !$past(driveCreep))
        else $error("Hold entered while driving");
    AST_HOLD_QUIET: assert property (
        holdAtTargetSignal |-> !driveRapid && !driveCreep) else $error("Drive on in hold");
    AST_STILL_ERR: assert property (
        holdAtTargetSignal && absDev > {1'b0, still_q >> 1} && mask_q[IRQ_STILLERR]
            && !(ctrlWr && regWdata[CTRL_START]) |-> ##[1:2] irq)
        else $error("Standstill exit not signalled");
endmodule

bind tam_top tam_top_sva u_tam_top_sva (.clk, .resetn, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .actualPos, .actualVel, .abortPinN, .driveRapid, .driveCreep,
    .driveFwd, .targetReachedFlag, .holdAtTargetSignal, .irq);
`default_nettype wire

// file: test/tam_power_model.sv
// Behavioural power controller and axis turning drive outputs into motion
`timescale 1ns/10ps
`default_nettype none
module tam_power_model
    import tam_pkg::*;
#(
    parameter int RAPID = 8,
    parameter int CREEP = 1
)
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 driveRapid,
    input  wire logic                 driveCreep,
    input  wire logic                 driveFwd,
    input  wire logic signed [DW-1:0] nudge,
    output logic signed [DW-1:0]      actualPos,
    output logic        [DW-1:0]      actualVel
);
    logic fwd_q;

    // Speed follows the contactors at once and coasts down one step a cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            actualPos <= '0;
            actualVel <= '0;
            fwd_q <= 1'b1;
        end else begin
            if (driveRapid || driveCreep) fwd_q <= driveFwd;
            if (driveRapid) actualVel <= DW'(RAPID);
            else if (driveCreep) actualVel <= DW'(CREEP);
            else if (actualVel != '0) actualVel <= actualVel - 1;
            actualPos <= actualPos + (fwd_q ? $signed(actualVel) : -$signed(actualVel)) + nudge;
        end
    end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking testbench for the target approach monitor
`timescale 1ns/10ps
`default_nettype none
module tb
    import tam_pkg::*;
;
    logic clk, resetn, regWrite, regRead, abortPinN, rdSeen;
    logic [AW-1:0] regAddr;
    logic [DW-1:0] regWdata, regRdata, actualVel, tgt, expQ[$], mskQ[$];
    logic signed [DW-1:0] actualPos, nudge;
    logic driveRapid, driveCreep, driveFwd, targetReachedFlag, holdAtTargetSignal, irq;
    int errCount = 0;
    int nTests = 0;
    wire [2:0] waitSig = {driveCreep, holdAtTargetSignal, targetReachedFlag};

    tam_top u_tam_top (.clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .actualPos, .actualVel, .abortPinN, .driveRapid, .driveCreep, .driveFwd,
        .targetReachedFlag, .holdAtTargetSignal, .irq);
    tam_power_model u_tam_power_model (.clk, .resetn, .driveRapid, .driveCreep, .driveFwd,
        .nudge, .actualPos, .actualVel);

    ////////////////////////////////////////////////////////////////////////////
    // Clock generation
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wrapUp();
        $display("Mismatches %0d of %0d checks", errCount, nTests);
        if (errCount == 0 && nTests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // Read request notes the expected word and the bits that matter
    task rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        mskQ.push_back(m);
        @(posedge clk);
        regRead <= 1'b0;
    endtask

    // Bounded wait on creep (k=2), the hold signal (k=1) or the reached flag (k=0)
    task waitFor(input int k, input logic v);
        for (int i = 0; i < 3000 && waitSig[k] !== v; i++)
            @(posedge clk);
        if (waitSig[k] !== v) begin
            errCount++;
            wrapUp();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read data monitor: compares the word of the cycle after each read strobe
    always @(posedge clk) begin
        rdSeen <= regRead;
        if (rdSeen === 1'b1 && expQ.size() > 0) cmp(regRdata & mskQ[0], expQ[0] & mskQ[0]);
        if (rdSeen === 1'b1 && expQ.size() > 0) void'(expQ.pop_front());
        if (rdSeen === 1'b1 && mskQ.size() > 0) void'(mskQ.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {resetn, regWrite, regRead, regAddr, regWdata, nudge} = '0;
        abortPinN = 1'b1;
        void'($urandom(1));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(OFS_STATUS, RST_WORD, '1);
        rd(OFS_IRQSTAT, RST_WORD, '1);
        rd(8'h30, 32'h0000_0000, '1);
        tgt = 32'd1000 + ($urandom % 500);
        wr(OFS_TARGET, tgt);
        wr(OFS_SWOVER, 32'h0000_0050);
        wr(OFS_SWOFF, 32'h0000_000C);
        wr(OFS_TGTRANGE, 32'h0000_0016);
        wr(OFS_STILLRNG, 32'h0000_0028);
        wr(OFS_STILLVEL, 32'h0000_0000);
        wr(OFS_MONPERIOD, 32'h0000_00C8);
        wr(OFS_IRQMASK, 32'h0000_000F);
        rd(OFS_SWOVER, 32'h0000_0050, '1);
        wr(OFS_CTRL, 32'h0000_0001);
        waitFor(2, 1'b1);
        cmp(driveRapid, 1'b0);
        waitFor(0, 1'b1);
        cmp(holdAtTargetSignal, 1'b1);
        rd(OFS_STATUS, 32'h0000_001E, 32'h0000_007F);
        rd(OFS_IRQSTAT, 32'h0000_0001, '1);
        cmp(irq, 1'b1);
        wr(OFS_IRQSTAT, 32'h0000_0001);
        nudge <= 32'sd40;
        @(posedge clk);
        nudge <= -32'sd40;
        @(posedge clk);
        nudge <= '0;
        rd(OFS_IRQSTAT, 32'h0000_0004, '1);
        cmp(irq, 1'b1);
        wr(OFS_IRQSTAT, 32'h0000_000F);
        rd(OFS_IRQSTAT, 32'h0000_0000, '1);
        cmp(irq, 1'b0);
        wr(OFS_IRQMASK, 32'h0000_0003);
        wr(OFS_TGTRANGE, 32'h0000_0000);
        wr(OFS_MONPERIOD, 32'h0000_0014);
        wr(OFS_TARGET, actualPos - 300 - ($urandom % 200));
        wr(OFS_CTRL, 32'h0000_0001);
        waitFor(1, 1'b0);
        waitFor(1, 1'b1);
        rd(OFS_IRQSTAT, 32'h0000_0002, 32'h0000_0003);
        cmp(targetReachedFlag, 1'b0);
        for (int m = 1; m < 3; m++) begin
            wr(OFS_CTRL, 32'h0000_0001 | (m << CTRL_MODE_LO) | ((m & 1) << CTRL_DIR));
            repeat (20) @(posedge clk);
            cmp({driveRapid, driveFwd}, {1'b1, 1'(m & 1)});
            wr(OFS_CTRL, 32'h0000_0002);
            cmp(targetReachedFlag, 1'b0);
            rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0007);
        end
        wr(OFS_IRQSTAT, 32'h0000_000F);
        wr(OFS_TARGET, actualPos + 5000);
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (10) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0004);
        rd(OFS_IRQSTAT, 32'h0000_0008, 32'h0000_0008);
        wr(OFS_IRQSTAT, 32'h0000_000F);
        wr(OFS_IRQMASK, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (5) @(posedge clk);
        abortPinN <= 1'b0;
        repeat (8) @(posedge clk);
        cmp({driveRapid, driveCreep}, 2'b00);
        abortPinN <= 1'b1;
        rd(OFS_IRQSTAT, 32'h0000_0008, 32'h0000_0008);
        cmp(irq, 1'b0);
        repeat (3) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0000, 32'h0000_007F);
        wrapUp();
    end
endmodule
`default_nettype wire
